// ---- verilog/vic_core.sv ----
// Vectored interrupt controller with APB register file
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_core (
  input  wire logic                 clk,          // System clock
  input  wire logic                 rst_n,        // Async reset, active low
  input  wire logic                 psel,         // APB select
  input  wire logic                 penable,      // APB enable
  input  wire logic                 pwrite,       // APB write
  input  wire logic [7:0]           paddr,        // APB byte address
  input  wire logic [31:0]          pwdata,       // APB write data
  output logic [31:0]               prdata,       // APB read data
  output logic                      pready,       // APB ready
  output logic                      pslverr,      // APB error
  input  wire logic                 extIrqPinA,   // External pin A
  input  wire logic                 extIrqPinB,   // External pin B
  input  wire logic                 converterEvt, // Conversion done
  input  wire logic                 tick0Evt,     // Time base 0 overflow
  input  wire logic                 tick1Evt,     // Time base 1 overflow
  input  wire logic                 serialEvt,    // Serial module event
  input  wire logic                 asyncSerEvt,  // UART event
  input  wire logic                 secondSpiEvt, // Second SPI event
  input  wire logic [7:0]           timerEvt,     // Timer match events
  input  wire logic                 eepromEvt,    // Data EEPROM event
  input  wire logic                 lowVoltEvt,   // Low-voltage event
  input  wire logic                 irqWindow,    // Core can be interrupted
  input  wire logic                 stackFull,    // Return stack full
  input  wire logic [`VIC_PC_W-1:0] nextPc,       // Next instruction address
  input  wire logic                 retFromIrq,   // Return from interrupt
  output logic                      irqTake,      // Push and load vector
  output logic [`VIC_PC_W-1:0]      irqVector,    // Vector address
  output logic [`VIC_PC_W-1:0]      pushPc,       // Address to push
  output logic                      popPc,        // Pop saved address
  output logic                      wakeUp        // Wake from low power
);
  localparam int NS = `VIC_NSRC;
  localparam int IW = `VIC_IDX_W;

  vic_pkg::vic_state_t s_q;
  vic_pkg::vic_state_t s_d;

  logic          evtA;
  logic          evtB;
  logic [NS-1:0] flag;
  logic [NS-1:0] en;
  logic [NS-1:0] pend;
  logic          found;
  logic [IW-1:0] idx;
  logic          take;
  logic          wrEn;
  logic          rdEn;
  logic [NS-1:0] clr;

  function automatic logic [7:0] vic_wr(input logic [7:0] cur,
                                         input logic       hit,
                                         input logic [7:0] wd,
                                         input logic [7:0] mask);
    return hit ? (wd & mask) : cur;
  endfunction : vic_wr

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge detection

  vic_edge u_edgeA (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin     (extIrqPinA),
    .edgeSel (s_q.edgeSel[1:0]),
    .evt     (evtA)
  );

  vic_edge u_edgeB (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin     (extIrqPinB),
    .edgeSel (s_q.edgeSel[3:2]), // [RULE2]
    .evt     (evtB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request vector in vector order

  // Groups stand in for timer, EEPROM and low-voltage sources
  assign flag = {s_q.ctrl3[`VIC_SPI_F], s_q.ctrl2[7:4],
                 s_q.ctrl1[6:4], s_q.ctrl0[6:4]}; // [RULE15]
  assign en   = {s_q.ctrl3[`VIC_SPI_E], s_q.ctrl2[3:0],
                 s_q.ctrl1[2:0], s_q.ctrl0[3:1]};

  always_comb begin
    pend    = flag & en; // [RULE4]
    // Pins need a live edge select as well
    pend[0] = pend[0] && s_q.edgeSel[1:0] != `VIC_EDGE_OFF; // [RULE19]
    pend[1] = pend[1] && s_q.edgeSel[3:2] != `VIC_EDGE_OFF; // [RULE19]
  end

  vic_prio #(
    .N  (NS),
    .IW (IW)
  ) u_prio (
    .req   (pend),
    .found (found),
    .idx   (idx)
  );

  // Back-to-back takes are spaced by the registered pulse
  assign take = irqWindow && s_q.ctrl0[`VIC_GIE] && !stackFull &&
                found && !s_q.take; // [RULE5] [RULE11]
  assign clr  = take ? (NS'(1) << idx) : '0;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;
    logic [7:0] g0;
    logic [7:0] g1;
    logic [7:0] g2;
    logic [2:0] rise;
    rise = 3'h0;
    c0   = vic_wr(s_q.ctrl0, wrEn && paddr == `VIC_OFF_CTRL0,
                  pwdata[7:0], `VIC_MASK_CTRL0); // [RULE20]
    c1   = vic_wr(s_q.ctrl1, wrEn && paddr == `VIC_OFF_CTRL1,
                  pwdata[7:0], `VIC_MASK_CTRL1); // [RULE21]
    c2   = vic_wr(s_q.ctrl2, wrEn && paddr == `VIC_OFF_CTRL2,
                  pwdata[7:0], `VIC_MASK_CTRL2); // [RULE22]
    c3   = vic_wr(s_q.ctrl3, wrEn && paddr == `VIC_OFF_CTRL3,
                  pwdata[7:0], `VIC_MASK_CTRL3); // [RULE23]
    g0   = vic_wr(s_q.grp0, wrEn && paddr == `VIC_OFF_GRP0,
                  pwdata[7:0], `VIC_MASK_GRP0); // [RULE24]
    g1   = vic_wr(s_q.grp1, wrEn && paddr == `VIC_OFF_GRP1,
                  pwdata[7:0], `VIC_MASK_GRP1); // [RULE25]
    g2   = vic_wr(s_q.grp2, wrEn && paddr == `VIC_OFF_GRP2,
                  pwdata[7:0], `VIC_MASK_GRP2); // [RULE26]
    s_d  = s_q;
    s_d.edgeSel = 4'(vic_wr({4'h0, s_q.edgeSel},
                            wrEn && paddr == `VIC_OFF_EDGE,
                            pwdata[7:0], `VIC_MASK_EDGE));

    // Service clears the taken flag; a new event still wins
    c0[6:4] = c0[6:4] & ~clr[2:0]; // [RULE17]
    c1[6:4] = c1[6:4] & ~clr[5:3];
    c2[7:4] = c2[7:4] & ~clr[9:6];
    c3[`VIC_SPI_F] = c3[`VIC_SPI_F] & ~clr[10];
    if (take) begin
      c0[`VIC_GIE] = 1'b0; // [RULE8]
    end

    // Events set flags regardless of enables or blocking
    c0[`VIC_PINA_F] = c0[`VIC_PINA_F] | evtA; // [RULE18] [RULE9]
    c0[`VIC_PINB_F] = c0[`VIC_PINB_F] | evtB; // [RULE18]
    c0[`VIC_CONV_F] = c0[`VIC_CONV_F] | converterEvt; // [RULE3]
    c2[7]           = c2[7] | serialEvt; // [RULE3]
    c2[6]           = c2[6] | asyncSerEvt;
    c2[5]           = c2[5] | tick1Evt;
    c2[4]           = c2[4] | tick0Evt;
    c3[`VIC_SPI_F]  = c3[`VIC_SPI_F] | secondSpiEvt;
    g0[7:4]         = g0[7:4] | timerEvt[3:0];
    g1[7:4]         = g1[7:4] | timerEvt[7:4];
    g2[`VIC_EE_F]   = g2[`VIC_EE_F] | eepromEvt;
    g2[`VIC_LV_F]   = g2[`VIC_LV_F] | lowVoltEvt;

    // Group flag follows any member flag that newly sets
    rise[0] = |(g0[7:4] & ~s_q.grp0[7:4]);
    rise[1] = |(g1[7:4] & ~s_q.grp1[7:4]);
    rise[2] = |(g2[5:4] & ~s_q.grp2[5:4]);
    c1[6:4] = c1[6:4] | rise; // [RULE16]

    s_d.ctrl0 = c0;
    s_d.ctrl1 = c1;
    s_d.ctrl2 = c2;
    s_d.ctrl3 = c3;
    s_d.grp0  = g0;
    s_d.grp1  = g1;
    s_d.grp2  = g2;

    // Core handshake
    s_d.take = take;
    s_d.pop  = retFromIrq; // [RULE7]
    if (take) begin
      s_d.lastIdx  = idx;
      s_d.pushAddr = nextPc; // [RULE6]
      s_d.vecAddr  = `VIC_PC_W'(`VIC_VEC_BASE +
                     `VIC_PC_W'(idx) * `VIC_VEC_STEP); // [RULE6]
    end

    // Read data latched in the setup phase
    if (rdEn) begin
      s_d.slvErr = 1'b0;
      s_d.rdata  = '0;
      case (paddr)
        `VIC_OFF_EDGE: begin
          s_d.rdata[3:0] = s_q.edgeSel;
        end
        `VIC_OFF_CTRL0: begin
          s_d.rdata[7:0] = s_q.ctrl0;
        end
        `VIC_OFF_CTRL1: begin
          s_d.rdata[7:0] = s_q.ctrl1;
        end
        `VIC_OFF_CTRL2: begin
          s_d.rdata[7:0] = s_q.ctrl2;
        end
        `VIC_OFF_CTRL3: begin
          s_d.rdata[7:0] = s_q.ctrl3;
        end
        `VIC_OFF_GRP0: begin
          s_d.rdata[7:0] = s_q.grp0;
        end
        `VIC_OFF_GRP1: begin
          s_d.rdata[7:0] = s_q.grp1;
        end
        `VIC_OFF_GRP2: begin
          s_d.rdata[7:0] = s_q.grp2;
        end
        `VIC_OFF_STAT: begin
          s_d.rdata[7:0] = {stackFull, found, 2'h0, s_q.lastIdx};
        end
        default: begin
          s_d.slvErr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata    = s_q.rdata;
  assign pready    = 1'b1;
  assign pslverr   = s_q.slvErr;
  assign irqTake   = s_q.take;
  assign irqVector = s_q.vecAddr;
  assign pushPc    = s_q.pushAddr;
  assign popPc     = s_q.pop;
  assign wakeUp    = |{flag, s_q.grp0[7:4], s_q.grp1[7:4],
                       s_q.grp2[5:4]}; // [RULE14]

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_req;
    take;
  endsequence

  sequence s_take_done;
    ##1 irqTake && !s_q.ctrl0[`VIC_GIE];
  endsequence

  property p_take_entry;
    s_take_req |-> s_take_done;
  endproperty
  a_take_entry: assert property (p_take_entry) // [RULE8]
    else $error("global enable not cleared on service");

  property p_vector;
    logic [IW-1:0] i;
    (take, i = idx) |=> irqVector == `VIC_PC_W'(`VIC_VEC_BASE +
                        `VIC_PC_W'(i) * `VIC_VEC_STEP)
                        && pushPc == $past(nextPc);
  endproperty
  a_vector: assert property (p_vector) // [RULE6]
    else $error("wrong vector or pushed address");

  property p_gie_block;
    !s_q.ctrl0[`VIC_GIE] |-> ##1 !irqTake;
  endproperty
  a_gie_block: assert property (p_gie_block) // [RULE5]
    else $error("interrupt taken with global enable off");

  property p_enable_needed;
    irqTake |-> $past(en[idx]);
  endproperty
  a_enable_needed: assert property (p_enable_needed) // [RULE4]
    else $error("interrupt taken from disabled source");

  property p_stack_full;
    stackFull |=> !irqTake;
  endproperty
  a_stack_full: assert property (p_stack_full) // [RULE11]
    else $error("interrupt taken with full stack");

  property p_priority;
    irqTake |-> ($past(pend) & ((NS'(1) << s_q.lastIdx) - NS'(1))) == '0;
  endproperty
  a_priority: assert property (p_priority) // [RULE13]
    else $error("lower vector request was skipped");

  property p_event_sets;
    converterEvt |=> s_q.ctrl0[`VIC_CONV_F] && wakeUp;
  endproperty
  a_event_sets: assert property (p_event_sets) // [RULE3]
    else $error("converter event lost or no wake");

  property p_flag_held;
    s_q.ctrl0[`VIC_CONV_F] && !take && !wrEn |=> s_q.ctrl0[`VIC_CONV_F];
  endproperty
  a_flag_held: assert property (p_flag_held) // [RULE9]
    else $error("blocked request flag dropped");

  property p_pin_clear;
    take && idx == '0 && !evtA |=> !s_q.ctrl0[`VIC_PINA_F];
  endproperty
  a_pin_clear: assert property (p_pin_clear) // [RULE17]
    else $error("pin flag not cleared on service");

  property p_pin_set;
    evtA |=> s_q.ctrl0[`VIC_PINA_F];
  endproperty
  a_pin_set: assert property (p_pin_set) // [RULE18]
    else $error("pin edge did not set flag");

  property p_group;
    timerEvt[0] && !s_q.grp0[4] |=> s_q.ctrl1[`VIC_GRP_F0];
  endproperty
  a_group: assert property (p_group) // [RULE16]
    else $error("group flag did not follow member");

  property p_pop;
    retFromIrq |=> popPc ##1 !popPc || $past(retFromIrq);
  endproperty
  a_pop: assert property (p_pop) // [RULE7]
    else $error("return did not pop");

  property p_reserved;
    rdEn && paddr == `VIC_OFF_CTRL3 |=>
      (prdata[7:0] & ~`VIC_MASK_CTRL3) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) // [RULE23]
    else $error("reserved bits read nonzero");
endmodule : vic_core

// ---- verilog/vic_cfg.svh ----
// Constants of the vectored interrupt controller
// How it works
// (RULE1) Pin A edge select: 00 off, 01 rising, 10 falling, 11 both.
// (RULE2) Pin B edge select uses the same two-bit coding.
// (RULE3) A source event sets its request flag whatever the enables say.
// (RULE4) A set flag vectors only while its own enable is 1.
// (RULE5) Global enable at 0 blocks every interrupt.
// (RULE6) Taking an interrupt pushes the next address and loads the vector.
// (RULE7) Return from interrupt pops the saved address back.
// (RULE8) Servicing any interrupt clears the global enable.
// (RULE9) Requests while blocked still set and hold their flags.
// (RULE10) Software re-sets global enable inside a routine to allow nesting.
// (RULE11) A full stack holds off acknowledgement until it drains.
// (RULE12) Simultaneous enabled requests resolve by fixed priority.
// (RULE13) Priority follows vector order; the lowest vector wins.
// (RULE14) Any set flag wakes the device; software presets flags to mask. The code ORs flag levels, so a preset flag keeps wakeUp high.
// (RULE15) Timer, EEPROM and low-voltage sources share group vectors.
// (RULE16) A group flag sets when any member flag becomes set.
// (RULE17) Servicing a pin interrupt clears that pin's flag.
// (RULE18) A pin flag sets on the transition its edge select picks.
// (RULE19) Pin vectoring needs global enable, pin enable and a live edge.
// (RULE20) Control 0: converter, pin B, pin A flags 6..4; enables 3..0.
// (RULE21) Control 1: group 2..0 flags at 6..4, enables at 2..0.
// (RULE22) Control 2: serial, UART, tick1, tick0 flags 7..4, enables 3..0.
// (RULE23) Control 3: second SPI flag bit 4, enable bit 0.
// (RULE24) Group 0: ptimer0 A, P, stimer A, P flags 7..4, enables 3..0.
// (RULE25) Group 1: ptimer2 A, P, ptimer1 A, P flags 7..4, enables 3..0.
// (RULE26) Group 2: EEPROM flag 5, low-volt flag 4, enables 1 and 0.
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
`define VIC_OFF_EDGE   8'h00
`define VIC_OFF_CTRL0  8'h04
`define VIC_OFF_CTRL1  8'h08
`define VIC_OFF_CTRL2  8'h0c
`define VIC_OFF_CTRL3  8'h10
`define VIC_OFF_GRP0   8'h14
`define VIC_OFF_GRP1   8'h18
`define VIC_OFF_GRP2   8'h1c
`define VIC_OFF_STAT   8'h20
`define VIC_MASK_EDGE  8'h0f
`define VIC_MASK_CTRL0 8'h7f
`define VIC_MASK_CTRL1 8'h77
`define VIC_MASK_CTRL2 8'hff
`define VIC_MASK_CTRL3 8'h11
`define VIC_MASK_GRP0  8'hff
`define VIC_MASK_GRP1  8'hff
`define VIC_MASK_GRP2  8'h33
`define VIC_REG_RST    8'h00
`define VIC_EDGE_RISE  0
`define VIC_EDGE_FALL  1
`define VIC_EDGE_OFF   2'h0
`define VIC_GIE        0
`define VIC_PINA_E     1
`define VIC_PINB_E     2
`define VIC_CONV_E     3
`define VIC_PINA_F     4
`define VIC_PINB_F     5
`define VIC_CONV_F     6
`define VIC_GRP_F0     4
`define VIC_SPI_F      4
`define VIC_SPI_E      0
`define VIC_EE_F       5
`define VIC_LV_F       4
`define VIC_NSRC       11
`define VIC_IDX_W      4
`define VIC_PC_W       16
`define VIC_VEC_BASE   16'h0004
`define VIC_VEC_STEP   16'h0004
`endif

// ---- verilog/vic_pkg.sv ----
// Types of the vectored interrupt controller
`include "vic_cfg.svh"
package vic_pkg;
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } vic_sync_t;

  typedef struct packed {
    logic [3:0]              edgeSel;
    logic [7:0]              ctrl0;
    logic [7:0]              ctrl1;
    logic [7:0]              ctrl2;
    logic [7:0]              ctrl3;
    logic [7:0]              grp0;
    logic [7:0]              grp1;
    logic [7:0]              grp2;
    logic [31:0]             rdata;
    logic                    slvErr;
    logic                    take;
    logic                    pop;
    logic [`VIC_IDX_W-1:0]   lastIdx;
    logic [`VIC_PC_W-1:0]    vecAddr;
    logic [`VIC_PC_W-1:0]    pushAddr;
  } vic_state_t;
endpackage : vic_pkg

// ---- verilog/vic_edge.sv ----
// Pin synchroniser and edge-select detector
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_edge (
  input  wire logic       clk,     // System clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic       pin,     // Asynchronous pin level
  input  wire logic [1:0] edgeSel, // Edge select code
  output logic            evt      // One-cycle edge event
);
  vic_pkg::vic_sync_t s_q;
  vic_pkg::vic_sync_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Rising bit and falling bit of the code act independently
  assign evt = (s_q.sync & ~s_q.prev & edgeSel[`VIC_EDGE_RISE]) |
               (~s_q.sync & s_q.prev & edgeSel[`VIC_EDGE_FALL]); // [RULE1]
endmodule : vic_edge

// ---- verilog/vic_prio.sv ----
// Fixed-priority picker, lowest index wins
`timescale 1ns/1ps
module vic_prio #(
  parameter int N  = 11,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]  req,   // Pending enabled requests
  output logic               found, // Any request pending
  output logic [IW-1:0]      idx    // Winning index
);
  // Refuse sizes the index cannot cover
  if (N < 2 || (1 << IW) < N) begin : g_badSize
    $error("vic_prio: bad N or IW");
  end

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = IW'(i); // [RULE12] [RULE13]
      end
    end
  end
endmodule : vic_prio

// ---- verification/vic_core_model.sv ----
// Behavioural processor core facing the interrupt controller
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_core_model #(
  parameter int DEPTH = 2
) (
  input  wire logic                 clk,        // System clock
  input  wire logic                 rst_n,      // Async reset, active low
  input  wire logic                 winEn,      // Allow interruption
  input  wire logic                 retCmd,     // Start a return
  input  wire logic                 irqTake,    // Push and vector
  input  wire logic [`VIC_PC_W-1:0] irqVector,  // Vector address
  input  wire logic [`VIC_PC_W-1:0] pushPc,     // Address to push
  input  wire logic                 popPc,      // Pop saved address
  output logic                      irqWindow,  // Interruptible point
  output logic                      stackFull,  // Return stack full
  output logic [`VIC_PC_W-1:0]      nextPc,     // Next instruction
  output logic                      retFromIrq, // Return executed
  output logic [`VIC_PC_W-1:0]      pc          // Program counter
);
  logic [`VIC_PC_W-1:0] stack [DEPTH];
  int                   sp;

  assign irqWindow = winEn;
  assign stackFull = (sp == DEPTH);
  assign nextPc    = pc + 16'h0001;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc         <= 16'h0100;
      sp         <= 0;
      retFromIrq <= 1'b0;
    end else begin
      retFromIrq <= retCmd && (sp != 0);
      if (irqTake && sp < DEPTH) begin
        stack[sp] <= pushPc;
        sp        <= sp + 1;
        pc        <= irqVector;
      end else if (popPc && sp != 0) begin
        pc <= stack[sp-1];
        sp <= sp - 1;
      end else begin
        pc <= pc + 16'h0001;
      end
    end
  end
endmodule : vic_core_model

// ---- verification/vic_core_tb.sv ----
// Register-level testbench of the vectored interrupt controller
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_core_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, errSeen;
  logic [7:0]  paddr, rd, evt, timerEvt, off, msk;
  logic [31:0] pwdata, prdata;
  logic [1:0]  pin;
  logic        irqWindow, stackFull, retFromIrq, irqTake, popPc, wakeUp;
  logic        winEn, retCmd;
  logic [15:0] nextPc, irqVector, pushPc, corePc, lastVec, retPc;
  int          bad_count, cmp_count, takeCnt, popCnt;
  logic [7:0]  masks [8] = '{`VIC_MASK_EDGE, `VIC_MASK_CTRL0,
    `VIC_MASK_CTRL1, `VIC_MASK_CTRL2, `VIC_MASK_CTRL3, `VIC_MASK_GRP0,
    `VIC_MASK_GRP1, `VIC_MASK_GRP2};
  logic [7:0]  srcOff [8] = '{`VIC_OFF_CTRL0, `VIC_OFF_CTRL2, `VIC_OFF_CTRL2,
    `VIC_OFF_CTRL2, `VIC_OFF_CTRL2, `VIC_OFF_CTRL3, `VIC_OFF_GRP2,
    `VIC_OFF_GRP2};
  logic [7:0]  srcMsk [8] = '{8'h40, 8'h10, 8'h20, 8'h80, 8'h40, 8'h10,
    8'h20, 8'h10};

  vic_core vic_core_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrqPinA(pin[0]), .extIrqPinB(pin[1]), .converterEvt(evt[0]),
    .tick0Evt(evt[1]), .tick1Evt(evt[2]), .serialEvt(evt[3]),
    .asyncSerEvt(evt[4]), .secondSpiEvt(evt[5]), .timerEvt(timerEvt),
    .eepromEvt(evt[6]), .lowVoltEvt(evt[7]), .irqWindow(irqWindow),
    .stackFull(stackFull), .nextPc(nextPc), .retFromIrq(retFromIrq),
    .irqTake(irqTake), .irqVector(irqVector), .pushPc(pushPc),
    .popPc(popPc), .wakeUp(wakeUp));

  vic_core_model #(.DEPTH(2)) vic_core_model_i (.clk(clk), .rst_n(rst_n),
    .winEn(winEn), .retCmd(retCmd), .irqTake(irqTake),
    .irqVector(irqVector), .pushPc(pushPc), .popPc(popPc),
    .irqWindow(irqWindow), .stackFull(stackFull), .nextPc(nextPc),
    .retFromIrq(retFromIrq), .pc(corePc));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (irqTake === 1'b1) begin
      takeCnt++;
      lastVec = irqVector;
      retPc   = corePc;
    end
    if (popPc === 1'b1) begin
      popCnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata[7:0];
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] a, exp);
    apb(1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask : rdChk

  task automatic fire(input int b, input logic tmr);
    @(posedge clk);
    if (tmr) begin
      timerEvt[b] <= 1'b1;
    end else begin
      evt[b] <= 1'b1;
    end
    @(posedge clk);
    evt      <= 8'h00;
    timerEvt <= 8'h00;
  endtask : fire

  task automatic waitTake(input int n, input logic [15:0] idx);
    for (int k = 0; k < 20 && takeCnt != n; k++) @(posedge clk);
    check("takeCnt", takeCnt, n);
    check("irqVector", lastVec, `VIC_VEC_BASE + `VIC_VEC_STEP * idx);
  endtask : waitTake

  task automatic ret;
    @(posedge clk);
    retCmd <= 1'b1;
    @(posedge clk);
    retCmd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : ret

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, retCmd, winEn} = 6'h00;
    {paddr, evt, timerEvt, rd} = 32'h0;
    {pwdata, pin, errSeen} = 35'h0;
    bad_count = 0;
    cmp_count = 0;
    takeCnt   = 0;
    popCnt    = 0;
    lastVec = 16'h0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Register map, window held closed so flags are not serviced
    for (int i = 0; i < 8; i++) begin
      off = 8'(4 * i);
      rdChk("reset", off, `VIC_REG_RST);
      wr(off, 8'hff);
      rdChk("rw", off, masks[i]);
      wr(off, 8'h00);
    end
    wr(`VIC_OFF_CTRL1, 8'h00);
    apb(1'b0, 8'h24, 8'h00);
    check("pslverr", errSeen, 1'b1);
    check("unmapped", rd, 8'h00);
    // Events with enables off never vector
    winEn <= 1'b1;
    wr(`VIC_OFF_CTRL0, 8'h01);
    for (int b = 0; b < 8; b++) begin
      fire(b, 1'b0);
      msk = (srcOff[b] == `VIC_OFF_CTRL0) ? 8'h01 : 8'h00;
      rdChk("flag", srcOff[b], srcMsk[b] | msk);
      @(negedge clk);
      check("wakeUp", wakeUp, 1'b1);
      if (b >= 6) rdChk("group2", `VIC_OFF_CTRL1, 8'h40);
      wr(srcOff[b], msk);
      wr(`VIC_OFF_CTRL1, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      off = (i < 4) ? `VIC_OFF_GRP0 : `VIC_OFF_GRP1;
      fire(i, 1'b1);
      rdChk("timer", off, 8'(8'h10 << (i % 4)));
      rdChk("group", `VIC_OFF_CTRL1, 8'(8'h10 << (i / 4)));
      wr(off, 8'h00);
      wr(`VIC_OFF_CTRL1, 8'h00);
    end
    @(negedge clk);
    check("wakeUp", wakeUp, 1'b0);
    check("takeCnt", takeCnt, 0);
    // Global enable off, then priority between converter and tick0
    wr(`VIC_OFF_CTRL0, 8'h00);
    fire(1, 1'b0);
    fire(0, 1'b0);
    wr(`VIC_OFF_CTRL2, 8'h11);
    wr(`VIC_OFF_CTRL0, 8'h48);
    repeat (10) @(posedge clk);
    check("takeCnt", takeCnt, 0);
    wr(`VIC_OFF_CTRL0, 8'h49);
    waitTake(1, 16'd2);
    @(negedge clk);
    check("corePc", corePc, lastVec);
    check("pushPc", pushPc, retPc);
    rdChk("ctrl0", `VIC_OFF_CTRL0, 8'h08);
    rdChk("ctrl2", `VIC_OFF_CTRL2, 8'h11);
    wr(`VIC_OFF_CTRL0, 8'h09);
    waitTake(2, 16'd6);
    // Stack now full: held off until a return drains it
    fire(5, 1'b0);
    wr(`VIC_OFF_CTRL3, 8'h11);
    wr(`VIC_OFF_CTRL0, 8'h09);
    repeat (10) @(posedge clk);
    check("takeCnt", takeCnt, 2);
    ret();
    check("popCnt", popCnt, 1);
    waitTake(3, 16'd10);
    ret();
    ret();
    // Pin edge selection, every code on both pins
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(`VIC_OFF_CTRL0, 8'h00);
        wr(`VIC_OFF_EDGE, 8'(c << (2 * p)));
        pin[p] <= 1'b1;
        repeat (6) @(posedge clk);
        rdChk("rise", `VIC_OFF_CTRL0, c[0] ? 8'(8'h10 << p) : 8'h00);
        wr(`VIC_OFF_CTRL0, 8'h00);
        pin[p] <= 1'b0;
        repeat (6) @(posedge clk);
        rdChk("fall", `VIC_OFF_CTRL0, c[1] ? 8'(8'h10 << p) : 8'h00);
      end
    end
    wr(`VIC_OFF_CTRL0, 8'h00);
    wr(`VIC_OFF_EDGE, 8'h01);
    wr(`VIC_OFF_CTRL0, 8'h03);
    pin[0] <= 1'b1;
    waitTake(4, 16'd0);
    rdChk("ctrl0", `VIC_OFF_CTRL0, 8'h02);
    report_and_stop();
  end
endmodule : vic_core_tb
